// File: bsf_ctl.sv
// Branch prediction, speculation and forwarding control for the pipes
`timescale 1ns/10ps

// Summary of operation
// - ALU result written straight to move destination
// - Result forwarding only when second is move
// - Stored value handed to paired load
// - Bypass only for cacheable locations
// - Bypass stalls secondary pipe one clock
// - 256-entry 4-way target buffer at fetch
// - Unconditional hit redirects to stored target
// - Conditional hit follows stored history
// - Conditional miss predicts not taken
// - Four-state counter per buffer entry
// - Conditional branches go to primary only
// - Resolve in execute, writeback if paired
// - Correct prediction completes in one clock
// - Both paths prefetched on conditional hit, mispredict flushes
// - Penalty four from execute, five writeback
// - Eight-entry return stack, call push, return pop
// - At most four speculation levels
// - Predict, checkpoint, raise level, proceed
// - Resolve lowers level, release or restore
// - Speculative writes held until resolved
// - Halt speculation on listed conditions
// - Thirty-two physical registers mapped to architectural
module bsf_ctl (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 srst,
  // Fetch side
  input  wire bsf_pkg::bsf_fetch_t  fetchIn,
  output logic [31:0]               fetchAddr,
  output logic                      fetchRedirect,
  output logic                      predictTaken,
  output logic                      btbHit,
  output logic [31:0]               altPathAddr,
  output logic                      altPathValid,
  output logic                      fetchHold,
  // Decode side
  input  wire bsf_pkg::bsf_decode_t decodeIn,
  output logic                      secondaryBlock,
  output logic                      decodeStall,
  output logic                      ckptSave,
  output logic [bsf_pkg::PREG_W-1:0] newPreg,
  // Resolution side
  input  wire bsf_pkg::bsf_resolve_t resolveIn,
  input  wire logic                 fpComplete,
  output logic                      resolveInWb,
  output logic                      flush,
  output logic                      ckptRestore,
  output logic                      ckptRelease,
  // Speculation status
  input  wire logic                 exceptionFault,
  input  wire logic                 writeBufFull,
  output logic [2:0]                specLevel,
  output logic                      specHalted,
  output logic                      holdSpecWrites,
  // Paired instruction dependencies
  input  wire bsf_pkg::bsf_pair_t   pairIn,
  output logic                      resultForward,
  output logic                      forwardToMem,
  output logic                      memBypass,
  output logic                      skipMemRead,
  output logic                      secondaryStall
);
  localparam int S = bsf_pkg::BTB_SETS;
  localparam int W = bsf_pkg::BTB_WAYS;

  // Target buffer storage
  logic                         btbV_q [S][W];
  logic                         btbV_d [S][W];
  logic [bsf_pkg::TAG_W-1:0]    btbTag_q [S][W];
  logic [bsf_pkg::TAG_W-1:0]    btbTag_d [S][W];
  logic [31:0]                  btbTgt_q [S][W];
  logic [31:0]                  btbTgt_d [S][W];
  logic [1:0]                   btbCtr_q [S][W];
  logic [1:0]                   btbCtr_d [S][W];
  logic [bsf_pkg::WAY_W-1:0]    victim_q [S];
  logic [bsf_pkg::WAY_W-1:0]    victim_d [S];
  // Return stack, rename map
  logic [31:0]                  ras_q [bsf_pkg::RAS_DEPTH];
  logic [31:0]                  ras_d [bsf_pkg::RAS_DEPTH];
  logic [bsf_pkg::RAS_PTR_W-1:0] rasTop_q, rasTop_d;
  logic [3:0]                   rasCnt_q, rasCnt_d;
  logic [bsf_pkg::PREG_W-1:0]   map_q [bsf_pkg::NUM_ARCH];
  logic [bsf_pkg::PREG_W-1:0]   map_d [bsf_pkg::NUM_ARCH];
  logic [bsf_pkg::PREG_W-1:0]   alloc_q, alloc_d;
  // Speculation state
  bsf_pkg::bsf_spec_t           st_q, st_d;
  logic [2:0]                   lvl_q, lvl_d;
  logic [2:0]                   pen_q, pen_d;
  // Registered outputs
  logic [31:0] fAddr_q, fAddr_d, alt_q, alt_d;
  logic        redir_q, redir_d, pTk_q, pTk_d, hit_q, hit_d;
  logic        altV_q, altV_d, hold_q, hold_d;
  logic        secB_q, secB_d, dStall_q, dStall_d, save_q, save_d;
  logic [bsf_pkg::PREG_W-1:0] preg_q, preg_d;
  logic        inWb_q, inWb_d, flush_q, flush_d;
  logic        rest_q, rest_d, rel_q, rel_d;
  logic        halted_q, halted_d, holdW_q, holdW_d;
  logic        rFwd_q, rFwd_d, fMem_q, fMem_d;
  logic        byp_q, byp_d, skip_q, skip_d, yStall_q, yStall_d;

  // Lookup and update scratch
  logic [bsf_pkg::SET_W-1:0] fSet, rSet;
  logic [bsf_pkg::TAG_W-1:0] fTag, rTag;
  logic        lHit, uHit, specReq, haltCause, ckptOk;
  logic [1:0]  lCtr;
  logic [31:0] lTgt;
  logic [bsf_pkg::WAY_W-1:0] uWay;
  logic [2:0]  lvlTmp;

  always_comb begin
    btbV_d   = btbV_q;
    btbTag_d = btbTag_q;
    btbTgt_d = btbTgt_q;
    btbCtr_d = btbCtr_q;
    victim_d = victim_q;
    ras_d    = ras_q;
    rasTop_d = rasTop_q;
    rasCnt_d = rasCnt_q;
    map_d    = map_q;
    alloc_d  = alloc_q;
    fSet = fetchIn.pc[bsf_pkg::TAG_LSB-1:bsf_pkg::SET_LSB];
    fTag = fetchIn.pc[31:bsf_pkg::TAG_LSB];
    rSet = resolveIn.pc[bsf_pkg::TAG_LSB-1:bsf_pkg::SET_LSB];
    rTag = resolveIn.pc[31:bsf_pkg::TAG_LSB];
    lHit = 1'b0;
    lCtr = bsf_pkg::CTR_MIN;
    lTgt = fetchIn.seqPc;
    for (int w = 0; w < W; w++) begin
      if (btbV_q[fSet][w] && btbTag_q[fSet][w] == fTag) begin
        lHit = 1'b1;
        lCtr = btbCtr_q[fSet][w];
        lTgt = btbTgt_q[fSet][w];
      end
    end
    fAddr_d = fetchIn.seqPc;
    redir_d = 1'b0;
    pTk_d   = 1'b0;
    hit_d   = 1'b0;
    alt_d   = alt_q;
    altV_d  = 1'b0;
    if (fetchIn.valid && fetchIn.isRet && rasCnt_q != 4'h0) begin
      fAddr_d  = ras_q[rasTop_q];
      redir_d  = 1'b1;
      pTk_d    = 1'b1;
      rasTop_d = rasTop_q - 3'h1;
      rasCnt_d = rasCnt_q - 4'h1;
    end else if (fetchIn.valid && fetchIn.isBranch) begin
      hit_d = lHit;
      if (!fetchIn.isCond && lHit) begin
        fAddr_d = lTgt;
        redir_d = 1'b1;
        pTk_d   = 1'b1;
      end else if (fetchIn.isCond && lHit) begin
        pTk_d   = lCtr[1];
        fAddr_d = lCtr[1] ? lTgt : fetchIn.seqPc;
        redir_d = lCtr[1];
        alt_d   = lCtr[1] ? fetchIn.seqPc : lTgt;
        altV_d  = 1'b1;
      end
      // a miss keeps the sequential address
    end
    if (fetchIn.valid && fetchIn.isCall) begin
      // push return address; oldest entry is overwritten
      rasTop_d = rasTop_q + 3'h1;
      ras_d[rasTop_q + 3'h1] = fetchIn.seqPc;
      if (rasCnt_q != bsf_pkg::RAS_FULL) begin
        rasCnt_d = rasCnt_q + 4'h1;
      end
    end
    // train history on resolution, allocate taken misses
    uHit = 1'b0;
    uWay = victim_q[rSet];
    for (int w = 0; w < W; w++) begin
      if (btbV_q[rSet][w] && btbTag_q[rSet][w] == rTag) begin
        uHit = 1'b1;
        uWay = w[bsf_pkg::WAY_W-1:0];
      end
    end
    if (resolveIn.valid) begin
      if (uHit) begin
        btbTgt_d[rSet][uWay] = resolveIn.target;
        if (resolveIn.taken && btbCtr_q[rSet][uWay] != bsf_pkg::CTR_MAX)
          btbCtr_d[rSet][uWay] = btbCtr_q[rSet][uWay] + 2'h1;
        else if (!resolveIn.taken &&
                 btbCtr_q[rSet][uWay] != bsf_pkg::CTR_MIN)
          btbCtr_d[rSet][uWay] = btbCtr_q[rSet][uWay] - 2'h1;
      end else if (resolveIn.taken) begin
        btbV_d[rSet][uWay]   = 1'b1;
        btbTag_d[rSet][uWay] = rTag;
        btbTgt_d[rSet][uWay] = resolveIn.target;
        btbCtr_d[rSet][uWay] = bsf_pkg::CTR_INSTALL;
        victim_d[rSet]       = victim_q[rSet] + 2'h1;
      end
    end
    preg_d = preg_q;
    if (decodeIn.valid && decodeIn.writesReg) begin
      preg_d = alloc_q;
      map_d[decodeIn.archDest] = alloc_q;
      alloc_d = alloc_q + 5'h1;
    end
    // conditional branch never enters secondary pipe
    secB_d = decodeIn.valid && decodeIn.isCondBranch;
    // condition setter paired means writeback resolution
    inWb_d = resolveIn.valid && resolveIn.ccParallel;

    // Speculation level and halt control
    specReq   = decodeIn.valid && (decodeIn.isCondBranch || decodeIn.isFp);
    haltCause = (specReq && lvl_q == bsf_pkg::SPEC_MAX) || exceptionFault ||
                writeBufFull ||
                (decodeIn.valid && decodeIn.nonCkptWrite);
    // no new level while halted or full
    ckptOk  = specReq && st_q == bsf_pkg::SPEC_RUN && !haltCause &&
              lvl_q < bsf_pkg::SPEC_MAX;
    save_d  = ckptOk;
    lvlTmp  = ckptOk ? lvl_q + 3'h1 : lvl_q;
    // resolution or FP completion lowers level
    if ((resolveIn.valid || fpComplete) && lvlTmp != 3'h0)
      lvlTmp = lvlTmp - 3'h1;
    if (resolveIn.valid && fpComplete && lvlTmp != 3'h0)
      lvlTmp = lvlTmp - 3'h1;
    lvl_d   = lvlTmp;
    rel_d   = resolveIn.valid && !resolveIn.mispredict;
    rest_d  = 1'b0;
    flush_d = 1'b0;
    hold_d  = pen_q > 3'h1;
    pen_d   = pen_q != 3'h0 ? pen_q - 3'h1 : 3'h0;
    st_d    = st_q;
    case (st_q)
      bsf_pkg::SPEC_RUN: begin
        if (haltCause) st_d = bsf_pkg::SPEC_HALT;
      end
      bsf_pkg::SPEC_HALT: begin
        // leave once cause clears and a level is free
        if (!haltCause && lvl_q < bsf_pkg::SPEC_MAX)
          st_d = bsf_pkg::SPEC_RUN;
      end
      bsf_pkg::SPEC_RECOVER: begin
        if (pen_q <= 3'h1) st_d = bsf_pkg::SPEC_RUN;
      end
      default: st_d = bsf_pkg::SPEC_RUN;
    endcase
    if (resolveIn.valid && resolveIn.mispredict) begin
      // flush, restore next clock, refetch correct path
      flush_d = 1'b1;
      rest_d  = 1'b1;
      fAddr_d = resolveIn.taken ? resolveIn.target : resolveIn.seqPc;
      redir_d = 1'b1;
      pTk_d   = resolveIn.taken;
      pen_d   = resolveIn.ccParallel ? bsf_pkg::PEN_WB : bsf_pkg::PEN_EX;
      hold_d  = 1'b1;
      st_d    = bsf_pkg::SPEC_RECOVER;
    end
    halted_d = st_d == bsf_pkg::SPEC_HALT;
    // stall further branch and FP decode
    dStall_d = halted_d || lvl_d == bsf_pkg::SPEC_MAX;
    // hold writes while any level is open
    holdW_d  = lvl_d != 3'h0;

    // forward ALU result into a dependent move
    rFwd_d = pairIn.valid && pairIn.xIsAlu && pairIn.yIsMove &&
             pairIn.ySrcArch == pairIn.xDestArch;
    fMem_d = rFwd_d && pairIn.yDestMem;
    // bypass store data to paired load
    byp_d  = pairIn.valid && pairIn.xMemWrite && pairIn.yMemRead &&
             pairIn.sameAddr && pairIn.cacheable;
    skip_d = byp_d;
    // single clock secondary stall in place of the read
    yStall_d = byp_d && !yStall_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int s = 0; s < S; s++) begin
        victim_q[s] <= '0;
        for (int w = 0; w < W; w++) begin
          btbV_q[s][w]   <= 1'b0;
          btbTag_q[s][w] <= '0;
          btbTgt_q[s][w] <= '0;
          btbCtr_q[s][w] <= bsf_pkg::CTR_MIN;
        end
      end
      for (int i = 0; i < bsf_pkg::RAS_DEPTH; i++) ras_q[i] <= '0;
      for (int i = 0; i < bsf_pkg::NUM_ARCH; i++)
        map_q[i] <= i[bsf_pkg::PREG_W-1:0];
      alloc_q  <= 5'h8;
      rasTop_q <= '0;
      rasCnt_q <= '0;
      st_q     <= bsf_pkg::SPEC_RUN;
      lvl_q    <= '0;
      pen_q    <= '0;
      fAddr_q  <= '0;
      alt_q    <= '0;
      {redir_q, pTk_q, hit_q, altV_q, hold_q} <= '0;
      {secB_q, dStall_q, save_q, inWb_q, flush_q} <= '0;
      {rest_q, rel_q, halted_q, holdW_q} <= '0;
      {rFwd_q, fMem_q, byp_q, skip_q, yStall_q} <= '0;
      preg_q   <= '0;
    end else begin
      btbV_q   <= btbV_d;
      btbTag_q <= btbTag_d;
      btbTgt_q <= btbTgt_d;
      btbCtr_q <= btbCtr_d;
      victim_q <= victim_d;
      ras_q    <= ras_d;
      map_q    <= map_d;
      alloc_q  <= alloc_d;
      rasTop_q <= rasTop_d;
      rasCnt_q <= rasCnt_d;
      st_q     <= st_d;
      lvl_q    <= lvl_d;
      pen_q    <= pen_d;
      fAddr_q  <= fAddr_d;
      alt_q    <= alt_d;
      {redir_q, pTk_q, hit_q, altV_q, hold_q} <=
        {redir_d, pTk_d, hit_d, altV_d, hold_d};
      {secB_q, dStall_q, save_q, inWb_q, flush_q} <=
        {secB_d, dStall_d, save_d, inWb_d, flush_d};
      {rest_q, rel_q, halted_q, holdW_q} <=
        {rest_d, rel_d, halted_d, holdW_d};
      {rFwd_q, fMem_q, byp_q, skip_q, yStall_q} <=
        {rFwd_d, fMem_d, byp_d, skip_d, yStall_d};
      preg_q   <= preg_d;
    end
  end

  assign fetchAddr      = fAddr_q;
  assign fetchRedirect  = redir_q;
  assign predictTaken   = pTk_q;
  assign btbHit         = hit_q;
  assign altPathAddr    = alt_q;
  assign altPathValid   = altV_q;
  assign fetchHold      = hold_q;
  assign secondaryBlock = secB_q;
  assign decodeStall    = dStall_q;
  assign ckptSave       = save_q;
  assign newPreg        = preg_q;
  assign resolveInWb    = inWb_q;
  assign flush          = flush_q;
  assign ckptRestore    = rest_q;
  assign ckptRelease    = rel_q;
  assign specLevel      = lvl_q;
  assign specHalted     = halted_q;
  assign holdSpecWrites = holdW_q;
  assign resultForward  = rFwd_q;
  assign forwardToMem   = fMem_q;
  assign memBypass      = byp_q;
  assign skipMemRead    = skip_q;
  assign secondaryStall = yStall_q;
endmodule : bsf_ctl

// File: bsf_ctl_properties.sv
// Concurrent checks on the branch, speculation and forwarding ports
`timescale 1ns/10ps
module bsf_ctl_properties (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  srst,
  // Watched inputs
  input wire bsf_pkg::bsf_fetch_t   fetchIn,
  input wire bsf_pkg::bsf_decode_t  decodeIn,
  input wire bsf_pkg::bsf_resolve_t resolveIn,
  input wire bsf_pkg::bsf_pair_t    pairIn,
  // Watched outputs
  input wire logic [31:0]           fetchAddr,
  input wire logic                  btbHit,
  input wire logic                  predictTaken,
  input wire logic                  fetchHold,
  input wire logic                  secondaryBlock,
  input wire logic                  decodeStall,
  input wire logic                  ckptSave,
  input wire logic [2:0]            specLevel,
  input wire logic                  flush,
  input wire logic                  ckptRestore,
  input wire logic                  resolveInWb,
  input wire logic                  holdSpecWrites,
  input wire logic                  resultForward,
  input wire logic                  forwardToMem,
  input wire logic                  memBypass,
  input wire logic                  skipMemRead,
  input wire logic                  secondaryStall
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence holdEx; fetchHold [*4] ##1 !fetchHold; endsequence
  sequence holdWb; fetchHold [*5] ##1 !fetchHold; endsequence
  a_fwd_move: assert property (
    pairIn.valid && pairIn.xIsAlu && pairIn.yIsMove &&
    pairIn.ySrcArch == pairIn.xDestArch
    |=> resultForward && forwardToMem == $past(pairIn.yDestMem))
    else $error("dependent move not forwarded");
  a_fwd_only_move: assert property (
    pairIn.valid && !pairIn.yIsMove |=> !resultForward)
    else $error("forward on a non-move");
  a_byp_noncache: assert property (
    pairIn.valid && !pairIn.cacheable |=> !memBypass && !skipMemRead)
    else $error("bypass on non-cacheable location");
  a_stall_single: assert property (
    secondaryStall |=> !secondaryStall)
    else $error("secondary pipe stalled two clocks");
  a_block_primary: assert property (
    decodeIn.valid && decodeIn.isCondBranch && !decodeStall &&
    !decodeIn.nonCkptWrite |=> secondaryBlock)
    else $error("conditional branch not held to primary pipe");
  a_cond_miss: assert property (
    $past(fetchIn.valid && fetchIn.isCond && !resolveIn.valid) && !btbHit
    |-> !predictTaken && fetchAddr == $past(fetchIn.seqPc))
    else $error("missed conditional branch not sequential");
  a_pen_ex: assert property (
    resolveIn.valid && resolveIn.mispredict && !resolveIn.ccParallel
    |=> flush && ckptRestore ##0 holdEx)
    else $error("execute mispredict penalty wrong");
  a_pen_wb: assert property (
    resolveIn.valid && resolveIn.mispredict && resolveIn.ccParallel
    |=> flush && resolveInWb ##0 holdWb)
    else $error("writeback mispredict penalty wrong");
  a_level_cap: assert property (
    specLevel == bsf_pkg::SPEC_MAX && decodeIn.valid |=> !ckptSave)
    else $error("checkpoint beyond four levels");
  a_save_level: assert property (
    ckptSave |-> $past(specLevel) < bsf_pkg::SPEC_MAX && specLevel != 3'h0)
    else $error("checkpoint without level rise");
  a_hold_writes: assert property (
    holdSpecWrites == (specLevel != 3'h0))
    else $error("speculative write hold disagrees with level");
endmodule : bsf_ctl_properties

bind bsf_ctl bsf_ctl_properties i_bsf_ctl_properties (.clock, .srst,
  .fetchIn, .decodeIn, .resolveIn, .pairIn, .fetchAddr, .btbHit,
  .predictTaken, .fetchHold, .secondaryBlock, .decodeStall, .ckptSave,
  .specLevel, .flush, .ckptRestore, .resolveInWb, .holdSpecWrites,
  .resultForward, .forwardToMem, .memBypass, .skipMemRead, .secondaryStall);

// File: bsf_fetch_model.sv
// Fetch unit stand-in that presents fetch records to the control block
`timescale 1ns/10ps
module bsf_fetch_model (
  // Bench control
  input  wire logic          go,
  input  wire logic [3:0]    kind,
  input  wire logic [31:0]   pcReq,
  // Design feedback
  input  wire logic          fetchHold,
  // Fetch record
  output bsf_pkg::bsf_fetch_t fetchIn
);
  always_comb begin
    fetchIn = '0;
    // no new fetch while the flush penalty runs
    fetchIn.valid = go && !fetchHold;
    // Idle record shows a changed address, never a stale one
    fetchIn.pc = fetchIn.valid ? pcReq : ~pcReq;
    fetchIn.seqPc = fetchIn.pc + 32'h4;
    {fetchIn.isBranch, fetchIn.isCond, fetchIn.isCall, fetchIn.isRet} = kind;
  end
endmodule : bsf_fetch_model

// File: bsf_pkg.sv
// Shared constants and carrier types for branch and forwarding control
package bsf_pkg;
  // Branch target buffer geometry
  localparam int BTB_ENTRIES = 256;
  localparam int BTB_WAYS    = 4;
  localparam int BTB_SETS    = BTB_ENTRIES / BTB_WAYS;
  localparam int SET_LSB     = 2;
  localparam int SET_W       = 6;
  localparam int TAG_LSB     = SET_LSB + SET_W;
  localparam int TAG_W       = 32 - TAG_LSB;
  localparam int WAY_W       = 2;
  // Four-state history counter
  localparam logic [1:0] CTR_INSTALL = 2'h2;
  localparam logic [1:0] CTR_MAX     = 2'h3;
  localparam logic [1:0] CTR_MIN     = 2'h0;
  // Return stack
  localparam int RAS_DEPTH = 8;
  localparam int RAS_PTR_W = 3;
  localparam logic [3:0] RAS_FULL = 4'h8;
  // Speculation and recovery
  localparam logic [2:0] SPEC_MAX = 3'h4;
  localparam logic [2:0] PEN_EX   = 3'h4;
  localparam logic [2:0] PEN_WB   = 3'h5;
  // Rename pool
  localparam int NUM_PREG = 32;
  localparam int PREG_W   = 5;
  localparam int NUM_ARCH = 8;
  localparam int ARCH_W   = 3;

  typedef enum logic [1:0] {
    SPEC_RUN     = 2'b00,
    SPEC_HALT    = 2'b01,
    SPEC_RECOVER = 2'b10
  } bsf_spec_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] seqPc;
    logic        isBranch;
    logic        isCond;
    logic        isCall;
    logic        isRet;
  } bsf_fetch_t;

  typedef struct packed {
    logic              valid;
    logic              isCondBranch;
    logic              isFp;
    logic              nonCkptWrite;
    logic              writesReg;
    logic [ARCH_W-1:0] archDest;
  } bsf_decode_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] seqPc;
    logic [31:0] target;
    logic        taken;
    logic        mispredict;
    logic        ccParallel;
  } bsf_resolve_t;

  typedef struct packed {
    logic              valid;
    logic              xIsAlu;
    logic [ARCH_W-1:0] xDestArch;
    logic              yIsMove;
    logic [ARCH_W-1:0] ySrcArch;
    logic              yDestMem;
    logic              xMemWrite;
    logic              yMemRead;
    logic              sameAddr;
    logic              cacheable;
  } bsf_pair_t;
endpackage : bsf_pkg

// File: tb.sv
// Self-checking bench for branch, speculation and forwarding control
`timescale 1ns/10ps
module tb;
  typedef struct {int c; int s; logic [31:0] v;} bsf_note_t;
  localparam int ADR = 0, HIT = 1, TKN = 2, ALT = 3, ALTV = 4, HOLD = 5;
  localparam int FLU = 6, RST = 7, REL = 8, LVL = 9, SAV = 10, BLK = 11;
  localparam int DST = 12, HLT = 13, FWD = 14, FMEM = 15, BYP = 16;
  localparam int SKIP = 17, SST = 18, WBR = 19, HWR = 20, RDR = 21;
  localparam int NPR = 22;
  localparam logic [31:0] P = 32'h1040, T = 32'h4400;
  logic clock, srst, go, fpComplete, exceptionFault, writeBufFull;
  logic [3:0] kind;
  logic [31:0] pcReq, rnd, fetchAddr, altPathAddr;
  bsf_pkg::bsf_fetch_t fetchIn;
  bsf_pkg::bsf_decode_t decodeIn;
  bsf_pkg::bsf_resolve_t resolveIn;
  bsf_pkg::bsf_pair_t pairIn;
  logic fetchRedirect, predictTaken, btbHit, altPathValid, fetchHold;
  logic secondaryBlock, decodeStall, ckptSave, resolveInWb, flush;
  logic ckptRestore, ckptRelease, specHalted, holdSpecWrites;
  logic resultForward, forwardToMem, memBypass, skipMemRead, secondaryStall;
  logic [2:0] specLevel;
  logic [bsf_pkg::PREG_W-1:0] newPreg;
  // Staged stimulus, applied together one cycle at a time
  logic goN, fpN, excN, wbfN;
  logic [3:0] kindN;
  logic [31:0] pcN;
  bsf_pkg::bsf_decode_t decN;
  bsf_pkg::bsf_resolve_t resN;
  bsf_pkg::bsf_pair_t pairN;
  logic [21:0] flags;
  int cyc = 0;
  int miscompares = 0;
  int cmp_count = 0;
  bsf_note_t q[$];

  bsf_ctl i_bsf_ctl (.clock, .srst, .fetchIn, .fetchAddr, .fetchRedirect,
    .predictTaken, .btbHit, .altPathAddr, .altPathValid, .fetchHold,
    .decodeIn, .secondaryBlock, .decodeStall, .ckptSave, .newPreg,
    .resolveIn, .fpComplete, .resolveInWb, .flush, .ckptRestore,
    .ckptRelease, .exceptionFault, .writeBufFull, .specLevel, .specHalted,
    .holdSpecWrites, .pairIn, .resultForward, .forwardToMem, .memBypass,
    .skipMemRead, .secondaryStall);
  bsf_fetch_model i_bsf_fetch_model (.go, .kind, .pcReq, .fetchHold,
    .fetchIn);

  assign flags = {fetchRedirect, holdSpecWrites, resolveInWb, secondaryStall,
    skipMemRead, memBypass, forwardToMem, resultForward, specHalted,
    decodeStall, secondaryBlock, ckptSave, 1'b0, ckptRelease, ckptRestore,
    flush, fetchHold, altPathValid, 1'b0, predictTaken, btbHit, 1'b0};

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [31:0] sel(input int s);
    if (s == ADR) return fetchAddr;
    if (s == ALT) return altPathAddr;
    if (s == LVL) return {29'h0, specLevel};
    if (s == NPR) return {27'h0, newPreg};
    return {31'h0, flags[s]};
  endfunction : sel

  task automatic cmpv(input int s, input logic [31:0] got,
                      input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t output %0d got %h expected %h", $time, s, got, exp);
    end
  endtask : cmpv

  // Notes are taken off in order as each result cycle comes round
  always @(negedge clock) begin
    bsf_note_t n;
    while (q.size() != 0 && q[0].c <= cyc) begin
      n = q.pop_front();
      cmpv(n.s, (n.c == cyc) ? sel(n.s) : ~n.v, n.v);
    end
  end

  task automatic e(input int d, input int s, input logic [31:0] v);
    q.push_back('{cyc + d, s, v});
  endtask : e

  // Inputs are written once per time step, so no glitch between requests
  task automatic idle();
    @(posedge clock);
    #2;
    {go, fpComplete, exceptionFault, writeBufFull} = {goN, fpN, excN, wbfN};
    kind = kindN;
    pcReq = pcN;
    decodeIn = decN;
    resolveIn = resN;
    pairIn = pairN;
    {goN, fpN, excN, wbfN, kindN, pcN} = '0;
    decN = '0;
    resN = '0;
    pairN = '0;
  endtask : idle

  task automatic fetch(input logic [3:0] k, input logic [31:0] p);
    goN = 1'b1;
    kindN = k;
    pcN = p;
    idle();
  endtask : fetch

  task automatic dec();
    rnd = lfsr(rnd);
    decN = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, rnd[2:0]};
    idle();
  endtask : dec

  task automatic mis(input logic par, input int lvl);
    resN = '{1'b1, P, P + 32'h4, T, 1'b1, 1'b1, par};
    idle();
    e(1, FLU, 1);
    e(1, RST, 1);
    e(1, ADR, T);
    e(1, WBR, par);
    e(1, LVL, lvl);
    for (int k = 1; k <= 6; k++) e(k, HOLD, k < 5 + par);
    repeat (6) idle();
  endtask : mis

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial begin
    repeat (3000) @(posedge clock);
    $display("[FAIL] %0t run did not finish", $time);
    miscompares++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    {go, fpComplete, exceptionFault, writeBufFull} = '0;
    kind = '0;
    pcReq = '0;
    rnd = 32'h1e;
    decodeIn = '0;
    resolveIn = '0;
    pairIn = '0;
    {goN, fpN, excN, wbfN, kindN, pcN} = '0;
    decN = '0;
    resN = '0;
    pairN = '0;
    repeat (12) @(posedge clock);
    #2;
    srst = 1'b0;
    idle();
    e(1, LVL, 0);
    e(1, HWR, 0);
    for (int i = 0; i < 4; i++) begin
      pairN = '{1'b1, 1'b1, 3'h3, i[0], 3'h3, i[1], 1'b0, 1'b0, 1'b0, 1'b0};
      idle();
      e(1, FWD, i[0]);
      e(1, FMEM, i[0] & i[1]);
    end
    // Two bypasses back to back, then a non-cacheable one
    for (int i = 0; i < 3; i++) begin
      pairN = '{1'b1, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, i < 2};
      idle();
      e(1, BYP, i < 2);
      e(1, SKIP, i < 2);
      e(1, SST, i == 0);
    end
    $display("forwarding test done");
    for (int i = 1; i <= 5; i++) begin
      dec();
      e(1, SAV, i < 5);
      e(1, LVL, (i < 5) ? i : 4);
      if (i < 5) e(1, BLK, 1);
      e(1, NPR, 7 + i);
    end
    fpN = 1'b1;
    resN = '{1'b1, 32'h5000, 32'h5004, 32'h6000, 1'b0, 1'b0, 1'b0};
    idle();
    e(0, DST, 1);
    e(1, REL, 1);
    e(1, LVL, 2);
    e(1, HWR, 1);
    mis(1'b0, 1);
    mis(1'b1, 0);
    e(0, HWR, 0);
    $display("speculation test done");
    fetch(4'b1100, P);
    e(1, HIT, 1);
    e(1, TKN, 1);
    e(1, ADR, T);
    e(1, ALT, P + 32'h4);
    e(1, ALTV, 1);
    e(1, RDR, 1);
    fetch(4'b1000, P);
    e(1, ADR, T);
    rnd = lfsr(rnd);
    fetch(4'b1100, {4'h8, rnd[27:2], 2'h0});
    e(1, HIT, 0);
    e(1, ADR, pcReq + 32'h4);
    fetch(4'b1010, 32'h2000);
    fetch(4'b1010, 32'h2100);
    fetch(4'b1001, 32'h3000);
    e(1, ADR, 32'h2104);
    fetch(4'b1001, 32'h3100);
    e(1, ADR, 32'h2004);
    e(1, RDR, 1);
    $display("prediction test done");
    for (int i = 0; i < 2; i++) begin
      {excN, wbfN} = (i == 0) ? 2'b10 : 2'b01;
      dec();
      e(1, SAV, 0);
      e(1, HLT, 1);
      e(1, LVL, 0);
      idle();
    end
    $display("halt test done");
    repeat (3) idle();
    complete_run();
  end
endmodule : tb
